// ### design/ncl_byte_reader.sv
// module: one-byte read handshake towards the nonvolatile memory port
`timescale 1ns/10ps
`default_nettype none
module ncl_byte_reader (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic rd_start,
    input wire logic [7:0] rd_addr,
    output logic rd_valid,
    output logic [7:0] rd_data,
    output logic mem_req,
    output logic [7:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_data
);
    import ncl_pkg::*;

    ncl_rd_state_type q; // registered state
    ncl_rd_state_type next; // next state

    ////////////////////////////////////////////////////////////////////////////
    // request held until the memory acknowledges; a stray ack is ignored
    always_comb begin
        next = q;
        next.valid = 1'b0;
        if (!q.busy) begin
            // start ignored while a read is open
            if (rd_start) begin
                next.busy = 1'b1;
                next.req = 1'b1;
                next.addr = rd_addr;
            end
        end else if (mem_ack && q.req) begin
            // data taken in the ack cycle
            next.busy = 1'b0;
            next.req = 1'b0;
            next.valid = 1'b1;
            next.data = mem_data;
        end
        if (rst) begin
            next = NCL_RD_RESET;
        end
    end

    // single state register
    always_ff @(posedge clk_sys) begin
        q <= next;
    end

    assign rd_valid = q.valid;
    assign rd_data = q.data;
    assign mem_req = q.req;
    assign mem_addr = q.addr;

endmodule : ncl_byte_reader
`default_nettype wire

// ### design/ncl_loader.sv
// module: loads register defaults from nonvolatile configuration bytes
`timescale 1ns/10ps
`default_nettype none
module ncl_loader (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic nv_present,
    input wire logic rst_protect,
    input wire logic interchip_link_mode,
    input wire logic usb_attach_ready,
    output logic mem_req,
    output logic [7:0] mem_addr,
    input wire logic mem_ack,
    input wire logic [7:0] mem_data,
    output logic load_done,
    output ncl_pkg::ncl_flag_attributes_register_type flag_attributes_register,
    output ncl_pkg::ncl_hardware_configuration_register_type hardware_configuration_register,
    output ncl_pkg::ncl_phy_ind_type phy_indication_register,
    output ncl_pkg::ncl_link_type interchip_link_enable_register,
    output ncl_pkg::ncl_usb_type usb_config,
    output logic wuff0_load,
    output logic attach_pin_o,
    output logic attach_pin_oe_n
);
    import ncl_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // state and helpers

    ncl_main_type q; // registered state
    ncl_main_type next; // next state
    logic rd_valid; // byte returned, one cycle
    logic [7:0] rd_data; // byte value
    logic attach_active; // attach wanted now
    logic attach_level; // pin level when driven
    logic fire; // a byte is taken this cycle

    // memory address of each sequence entry
    function automatic logic [7:0] byte_addr(input logic [3:0] i);
        logic [7:0] a;
        a = ADDR_WAKE0;
        unique case (i)
            IDX_WAKE0: a = ADDR_WAKE0;
            IDX_WAKE1: a = ADDR_WAKE1;
            IDX_IND0: a = ADDR_IND0;
            IDX_IND1: a = ADDR_IND1;
            IDX_IND2: a = ADDR_IND2;
            IDX_IND3: a = ADDR_IND3;
            IDX_IND4: a = ADDR_IND4;
            IDX_CFG_B2: a = ADDR_CFG0_B2;
            IDX_CFG_B3: a = ADDR_CFG0_B3;
            default: a = ADDR_WAKE0; // indices above the last never occur
        endcase
        return a;
    endfunction : byte_addr

    ////////////////////////////////////////////////////////////////////////////
    // byte reader, one outstanding read at a time

    ncl_byte_reader u_reader (
        .clk_sys(clk_sys),
        .rst(rst),
        .rd_start(q.start),
        .rd_addr(q.addr),
        .rd_valid(rd_valid),
        .rd_data(rd_data),
        .mem_req(mem_req),
        .mem_addr(mem_addr),
        .mem_ack(mem_ack),
        .mem_data(mem_data)
    );

    assign fire = (q.st == ST_WAIT) && rd_valid;

    ////////////////////////////////////////////////////////////////////////////
    // next-state logic: sequencer, byte decode, attach pin, reset

    always_comb begin
        next = q;
        // pulses default low
        next.start = 1'b0;
        next.wuff0_load = 1'b0;
        // link mode strap is a pin, two flops before use
        next.link_sync = {q.link_sync[0], interchip_link_mode};

        unique case (q.st)
            // first cycle after reset: decide whether there is a memory
            ST_IDLE: begin
                if (nv_present) begin
                    next.st = ST_ISSUE;
                end else begin
                    // memoryless: reset defaults stand, protected ones kept
                    next.st = ST_DONE;
                    next.done = 1'b1;
                end
            end
            // launch the read of the current byte
            ST_ISSUE: begin
                next.start = 1'b1;
                next.addr = byte_addr(q.idx);
                next.st = ST_WAIT;
            end
            // wait for the byte and land it in its register
            ST_WAIT: begin
                if (rd_valid) begin
                    unique case (q.idx)
                        IDX_WAKE0: begin
                            // wake byte 0 into flag attributes
                            next.flag.wake_pin_signal_enable =
                                rd_data[WAKE0_MASTER_BIT];
                            // exact match wake gated by master enable
                            next.flag.exact_destination_match =
                                rd_data[WAKE0_EXACT_BIT] && rd_data[WAKE0_MASTER_BIT];
                        end
                        IDX_WAKE1: begin
                            // wake byte 1 into flag attributes
                            next.flag.attach_push_pull = rd_data[WAKE1_PP_BIT];
                            next.flag.attach_enable = rd_data[WAKE1_ATT_EN_BIT];
                            next.flag.attach_polarity = rd_data[WAKE1_POL_BIT];
                            next.flag.broadcast_wake = rd_data[WAKE1_BCAST_BIT];
                            next.flag.wakeup_frame_filter = rd_data[WAKE1_WAKEUP_FRAME_FILTER_BIT];
                            // filter 0 set up from memory only when enabled
                            next.wuff0_load = rd_data[WAKE1_WAKEUP_FRAME_FILTER_BIT];
                        end
                        IDX_IND0: begin
                            // upper nibble reserved, dropped
                            next.hw.indicator_enable = rd_data[IND0_EN_LSB +: 4];
                        end
                        IDX_IND1: begin
                            // pin1 in the high nibble, pin0 in the low
                            next.ind.func[7:0] = rd_data;
                        end
                        IDX_IND2: begin
                            // pin3 in the high nibble, pin2 in the low
                            next.ind.func[15:8] = rd_data;
                        end
                        IDX_IND3: begin
                            next.ind.behav[7:0] = rd_data;
                        end
                        IDX_IND4: begin
                            next.ind.behav[15:8] = rd_data;
                        end
                        IDX_CFG_B2: begin
                            // word0 bits 23:16; bit 16 belongs elsewhere
                            next.link.link_pin_swap = rd_data[B2_SWAP_BIT];
                            next.usb.low_power_allow = rd_data[B2_SUSP_BIT];
                            next.hw.sleep_indicator_select_cfg =
                                rd_data[B2_SLP_SEL_LSB +: 2];
                            next.hw.sleep_indicator_polarity =
                                rd_data[B2_SLP_POL_BIT];
                        end
                        IDX_CFG_B3: begin
                            // word0 bits 31:24; bits 26:24 reserved, dropped
                            next.link.link_50ohm_driver_enable =
                                rd_data[B3_EN50_BIT];
                            next.link.link_slew_tune = rd_data[B3_SLEW_BIT];
                            next.usb.squelch_tune_field =
                                rd_data[B3_SQU_LSB +: 3];
                        end
                        default: begin
                            // index past the last never occurs
                            next.st = ST_DONE;
                        end
                    endcase
                    // advance, or finish once every byte has landed
                    if (q.idx == IDX_LAST) begin
                        next.st = ST_DONE;
                        next.done = 1'b1;
                    end else begin
                        next.idx = q.idx + 4'h1;
                        next.st = ST_ISSUE;
                    end
                end
            end
            // loaded: values hold until the next reset
            ST_DONE: begin
                next.done = 1'b1;
            end
        endcase

        // attach pin: only after load, in link mode, when usb is ready
        attach_active = q.done && q.link_sync[1] && usb_attach_ready;
        attach_level = attach_active ? q.flag.attach_polarity
                                     : !q.flag.attach_polarity;
        if (!q.flag.attach_enable) begin
            // disabled: pin released, polarity and driver ignored
            next.attach_o = 1'b0;
            next.attach_oe_n = 1'b1;
        end else if (q.flag.attach_push_pull) begin
            // push-pull: always driven
            next.attach_o = attach_level;
            next.attach_oe_n = 1'b0;
        end else begin
            // open drain: drive low only, a high level is a release
            next.attach_o = 1'b0;
            next.attach_oe_n = attach_level;
        end

        // synchronous reset; protected indication registers survive it
        if (rst) begin
            next = NCL_MAIN_RESET;
            if (rst_protect) begin
                next.ind = q.ind;
            end
        end
    end

    // single state register
    always_ff @(posedge clk_sys) begin
        q <= next;
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs, all straight from the state register

    assign load_done = q.done;
    assign flag_attributes_register = q.flag;
    assign hardware_configuration_register = q.hw;
    assign phy_indication_register = q.ind;
    assign interchip_link_enable_register = q.link;
    assign usb_config = q.usb;
    assign wuff0_load = q.wuff0_load;
    assign attach_pin_o = q.attach_o;
    assign attach_pin_oe_n = q.attach_oe_n;

    ////////////////////////////////////////////////////////////////////////////
    // assertions

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // exact match wake never outlives a cleared master enable
    exact_gate_a: assert property (
        q.flag.exact_destination_match |-> q.flag.wake_pin_signal_enable)
        else $error("exact match wake set without master enable");

    // wake byte 0 lands gated
    wake0_load_a: assert property (
        (fire && q.idx == IDX_WAKE0) |=>
            (q.flag.exact_destination_match ==
             ($past(rd_data[WAKE0_EXACT_BIT]) && $past(rd_data[WAKE0_MASTER_BIT]))))
        else $error("wake byte 0 decoded wrongly");

    // broadcast wake copied from wake byte 1
    bcast_load_a: assert property (
        (fire && q.idx == IDX_WAKE1) |=>
            (q.flag.broadcast_wake == $past(rd_data[WAKE1_BCAST_BIT])))
        else $error("broadcast wake bit decoded wrongly");

    // filter 0 set-up pulse lasts exactly one cycle
    wakeup_frame_filter_pulse_a: assert property (
        (fire && q.idx == IDX_WAKE1 && rd_data[WAKE1_WAKEUP_FRAME_FILTER_BIT]) |=>
            q.wuff0_load ##1 !q.wuff0_load)
        else $error("filter 0 load pulse wrong");

    // attach disabled leaves the pin released
    attach_off_a: assert property (
        !q.flag.attach_enable |=> (q.attach_oe_n && !q.attach_o))
        else $error("attach pin driven while disabled");

    // open drain never drives high, push-pull always drives
    drive_type_a: assert property (
        q.flag.attach_enable |=>
            ($past(q.flag.attach_push_pull) ? !q.attach_oe_n : !q.attach_o))
        else $error("attach driver type wrong");

    // outside link mode the pin rests at its inactive level
    attach_mode_a: assert property (
        (q.done && q.flag.attach_enable && q.flag.attach_push_pull && !q.link_sync[1])
            |=> (q.attach_o == !q.flag.attach_polarity))
        else $error("attach asserted outside link mode");

    // attach asserted follows ready one cycle later
    attach_ready_a: assert property (
        (q.done && q.flag.attach_enable && q.flag.attach_push_pull &&
         q.link_sync[1] && usb_attach_ready) |=>
            (q.attach_o == q.flag.attach_polarity))
        else $error("attach not asserted when ready");

    // indicator function byte 1 lands whole
    ind_func_a: assert property (
        (fire && q.idx == IDX_IND1) |=> (q.ind.func[7:0] == $past(rd_data)))
        else $error("indicator pin 0 and 1 functions wrong");

    // behaviour word high byte
    behav_load_a: assert property (
        (fire && q.idx == IDX_IND4) |=> (q.ind.behav[15:8] == $past(rd_data)))
        else $error("indicator behaviour high byte wrong");

    // link slew and squelch fields from flags word0 top byte
    link_copy_a: assert property (
        (fire && q.idx == IDX_CFG_B3) |=>
            ((q.link.link_slew_tune == $past(rd_data[B3_SLEW_BIT])) &&
             (q.usb.squelch_tune_field == $past(rd_data[B3_SQU_LSB +: 3]))))
        else $error("link or squelch field wrong");

    // completion only after the last byte, or with no memory
    done_order_a: assert property (
        $rose(q.done) |->
            (($past(q.idx) == IDX_LAST) || !$past(nv_present)))
        else $error("load done before the last byte");

    // indicator enables from indicator byte 0
    ind_enable_a: assert property (
        (fire && q.idx == IDX_IND0) |=>
            (q.hw.indicator_enable == $past(rd_data[IND0_EN_LSB +: 4])))
        else $error("indicator enables wrong");

    // pin 3 and pin 2 functions from indicator byte 2
    ind_func_hi_a: assert property (
        (fire && q.idx == IDX_IND2) |=> (q.ind.func[15:8] == $past(rd_data)))
        else $error("indicator pin 2 and 3 functions wrong");

    // sleep indicator fields from flags word0 byte 2
    sleep_copy_a: assert property (
        (fire && q.idx == IDX_CFG_B2) |=>
            ((q.hw.sleep_indicator_select_cfg == $past(rd_data[B2_SLP_SEL_LSB +: 2])) &&
             (q.hw.sleep_indicator_polarity == $past(rd_data[B2_SLP_POL_BIT]))))
        else $error("sleep indicator fields wrong");

    // low power permission and pin swap from the same byte
    susp_swap_a: assert property (
        (fire && q.idx == IDX_CFG_B2) |=>
            ((q.usb.low_power_allow == $past(rd_data[B2_SUSP_BIT])) &&
             (q.link.link_pin_swap == $past(rd_data[B2_SWAP_BIT]))))
        else $error("low power or pin swap wrong");

    // protected indication registers ride through reset, so watched during it
    protect_keep_a: assert property (disable iff (1'b0)
        (rst && rst_protect) |=> (q.ind == $past(q.ind)))
        else $error("protected indication registers lost in reset");

    // an open read holds request and address until acknowledged
    req_hold_a: assert property (
        (mem_req && !mem_ack) |=> (mem_req && $stable(mem_addr)))
        else $error("memory request dropped before acknowledge");

    // main scenarios
    load_full_c: cover property ($rose(q.done) && $past(q.st) == ST_WAIT);
    load_none_c: cover property ($rose(q.done) && $past(q.st) == ST_IDLE);
    attach_on_c: cover property (q.flag.attach_enable && attach_active ##1 !q.attach_oe_n);
    wakeup_frame_filter_c: cover property (q.wuff0_load);

endmodule : ncl_loader
`default_nettype wire

// ### design/ncl_pkg.sv
// package: constants and carrier types of the nonvolatile config loader
`default_nettype none
// Function
// - wake byte0 bit0 enables exact-match wakeup
// - master wake enable low ignores exact-match bit
// - wake bytes supply flag attributes defaults
// - wake byte1 bit6 picks attach driver type
// - wake byte1 bit5 enables attach pin signalling
// - wake byte1 bit4 polarity, ignored when disabled
// - wake byte1 bit1 enables broadcast packet wakeup
// - wake byte1 bit0 enables frames, loads filter 0
// - attach pin only in inter-chip link mode
// - indicator byte0 bits3:0 enable indicator pins
// - indicator byte1 loads pin1 and pin0 functions
// - indicator byte2 loads pin3 and pin2 functions
// - indicator bytes3 and 4 load behaviour word
// - reset protection keeps indicator registers over reset
// - flags word0 bits31,30,21 feed link register
// - flags word0 bits29:27 feed squelch tune field
// - flags word0 bit20 feeds low power permission
// - flags word0 bits19:17 feed sleep indicator fields
// - wake byte0 bit7 gates byte0 wake parameters
package ncl_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // byte addresses in the nonvolatile memory
    localparam logic [7:0] ADDR_WAKE0 = 8'h08;
    localparam logic [7:0] ADDR_WAKE1 = 8'h09;
    localparam logic [7:0] ADDR_IND0 = 8'h0a;
    localparam logic [7:0] ADDR_IND1 = 8'h0b;
    localparam logic [7:0] ADDR_IND2 = 8'h0c;
    localparam logic [7:0] ADDR_IND3 = 8'h0d;
    localparam logic [7:0] ADDR_IND4 = 8'h0e;
    localparam logic [7:0] ADDR_CFG0_B2 = 8'h12; // flags word0 bits 23:16
    localparam logic [7:0] ADDR_CFG0_B3 = 8'h13; // flags word0 bits 31:24

    // read sequence index of each byte
    localparam logic [3:0] IDX_WAKE0 = 4'h0;
    localparam logic [3:0] IDX_WAKE1 = 4'h1;
    localparam logic [3:0] IDX_IND0 = 4'h2;
    localparam logic [3:0] IDX_IND1 = 4'h3;
    localparam logic [3:0] IDX_IND2 = 4'h4;
    localparam logic [3:0] IDX_IND3 = 4'h5;
    localparam logic [3:0] IDX_IND4 = 4'h6;
    localparam logic [3:0] IDX_CFG_B2 = 4'h7;
    localparam logic [3:0] IDX_CFG_B3 = 4'h8;
    localparam logic [3:0] IDX_LAST = 4'h8;

    // field positions inside the bytes
    localparam int WAKE0_MASTER_BIT = 7;
    localparam int WAKE0_EXACT_BIT = 0;
    localparam int WAKE1_PP_BIT = 6;
    localparam int WAKE1_ATT_EN_BIT = 5;
    localparam int WAKE1_POL_BIT = 4;
    localparam int WAKE1_BCAST_BIT = 1;
    localparam int WAKE1_WAKEUP_FRAME_FILTER_BIT = 0;
    localparam int IND0_EN_LSB = 0;
    localparam int B3_EN50_BIT = 7;   // word0 bit 31
    localparam int B3_SLEW_BIT = 6;   // word0 bit 30
    localparam int B3_SQU_LSB = 3;    // word0 bits 29:27
    localparam int B2_SWAP_BIT = 5;   // word0 bit 21
    localparam int B2_SUSP_BIT = 4;   // word0 bit 20
    localparam int B2_SLP_SEL_LSB = 2; // word0 bits 19:18
    localparam int B2_SLP_POL_BIT = 1; // word0 bit 17

    ////////////////////////////////////////////////////////////////////////////
    // loader states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_ISSUE = 2'b01,
        ST_WAIT = 2'b10,
        ST_DONE = 2'b11
    } ncl_state_type;

    // flag attributes register defaults
    typedef struct packed {
        logic wake_pin_signal_enable;
        logic exact_destination_match;
        logic broadcast_wake;
        logic wakeup_frame_filter;
        logic attach_push_pull;
        logic attach_enable;
        logic attach_polarity;
    } ncl_flag_attributes_register_type;

    // hardware configuration register defaults
    typedef struct packed {
        logic [3:0] indicator_enable;
        logic [1:0] sleep_indicator_select_cfg;
        logic sleep_indicator_polarity;
    } ncl_hardware_configuration_register_type;

    // phy indication mode select and behaviour registers
    typedef struct packed {
        logic [15:0] func;
        logic [15:0] behav;
    } ncl_phy_ind_type;

    // inter-chip link enable register defaults
    typedef struct packed {
        logic link_50ohm_driver_enable;
        logic link_slew_tune;
        logic link_pin_swap;
    } ncl_link_type;

    // usb analog front end and usb configuration zero defaults
    typedef struct packed {
        logic [2:0] squelch_tune_field;
        logic low_power_allow;
    } ncl_usb_type;

    // whole state of the loader
    typedef struct packed {
        ncl_state_type st;
        logic [3:0] idx;
        logic start;
        logic [7:0] addr;
        logic done;
        logic wuff0_load;
        logic attach_o;
        logic attach_oe_n;
        logic [1:0] link_sync;
        ncl_flag_attributes_register_type flag;
        ncl_hardware_configuration_register_type hw;
        ncl_phy_ind_type ind;
        ncl_link_type link;
        ncl_usb_type usb;
    } ncl_main_type;

    // whole state of the byte reader
    typedef struct packed {
        logic busy;
        logic req;
        logic [7:0] addr;
        logic valid;
        logic [7:0] data;
    } ncl_rd_state_type;

    // all clear after reset, except that the attach pin is released, not driven low
    localparam ncl_main_type NCL_MAIN_RESET = '{
        st: ST_IDLE, idx: 4'h0, start: 1'b0, addr: 8'h00, done: 1'b0,
        wuff0_load: 1'b0, attach_o: 1'b0, attach_oe_n: 1'b1, link_sync: 2'b00,
        flag: '0, hw: '0, ind: '0, link: '0, usb: '0};
    localparam ncl_rd_state_type NCL_RD_RESET = '0;

endpackage : ncl_pkg
`default_nettype wire

// ### verif/ncl_mem_model.sv
// memory model: answers byte reads from a stored image, promptly or slowly
`timescale 1ns/10ps
`default_nettype none
module ncl_mem_model (
    input wire logic clk_sys,
    input wire logic slow,
    input wire logic mem_req,
    input wire logic [7:0] mem_addr,
    output logic mem_ack,
    output logic [7:0] mem_data
);
    logic [7:0] image [0:255]; // stored bytes, kept consistent by the bench
    logic [7:0] seen [$]; // addresses answered, in order
    int waits; // wait cycles spent on the open request
    initial begin
        mem_ack = 1'b0;
        mem_data = 8'h00;
        waits = 0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // one-cycle answer after zero or two waits
    always @(posedge clk_sys) begin
        if (mem_ack || !mem_req) begin
            // idle or released: data bus keeps changing so stale bytes never pass
            mem_ack <= 1'b0;
            mem_data <= ~mem_data;
            waits <= 0;
        end else if (waits >= (slow ? 2 : 0)) begin
            mem_ack <= 1'b1;
            mem_data <= image[mem_addr];
            seen.push_back(mem_addr);
        end else begin
            waits <= waits + 1;
        end
    end
endmodule : ncl_mem_model
`default_nettype wire

// ### verif/tb_top.sv
// testbench: loads images through the memory model, checks defaults and pin
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    import ncl_pkg::*;
    logic clk_sys = 1'b0, rst = 1'b1, nv_present = 1'b1, rst_protect = 1'b0;
    logic interchip_link_mode = 1'b1, usb_attach_ready = 1'b0, slow = 1'b0;
    logic mem_req, mem_ack, load_done, wuff0_load, attach_pin_o, attach_pin_oe_n;
    logic [7:0] mem_addr, mem_data;
    ncl_flag_attributes_register_type flag_attributes_register;
    ncl_hardware_configuration_register_type hardware_configuration_register;
    ncl_phy_ind_type phy_indication_register;
    ncl_link_type interchip_link_enable_register;
    ncl_usb_type usb_config;
    int fails = 0, samples_checked = 0, pulses = 0;
    logic [7:0] img [0:8]; // current image, in read order
    logic [7:0] addrs [0:8] = '{ADDR_WAKE0, ADDR_WAKE1, ADDR_IND0, ADDR_IND1, ADDR_IND2,
        ADDR_IND3, ADDR_IND4, ADDR_CFG0_B2, ADDR_CFG0_B3};

    ncl_loader u_ncl_loader (.clk_sys, .rst, .nv_present, .rst_protect,
        .interchip_link_mode, .usb_attach_ready, .mem_req, .mem_addr, .mem_ack,
        .mem_data, .load_done, .flag_attributes_register,
        .hardware_configuration_register, .phy_indication_register,
        .interchip_link_enable_register, .usb_config, .wuff0_load, .attach_pin_o,
        .attach_pin_oe_n);
    ncl_mem_model u_ncl_mem_model (.clk_sys, .slow, .mem_req, .mem_addr, .mem_ack,
        .mem_data);

    always #2 clk_sys = ~clk_sys;
    // count filter-load pulses
    always @(posedge clk_sys) begin
        if (wuff0_load === 1'b1) pulses++;
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // reset for ten cycles, then wait bounded for completion
    task automatic do_reset(input logic prot, input logic nv);
        @(negedge clk_sys);
        rst = 1'b1;
        rst_protect = prot;
        nv_present = nv;
        repeat (10) @(negedge clk_sys);
        chk({attach_pin_o, attach_pin_oe_n}, 2'b01);
        rst = 1'b0;
        for (int i = 0; i < 300 && load_done !== 1'b1; i++) @(negedge clk_sys);
        chk(load_done, 1);
    endtask : do_reset
    // store an image, load it and compare every default against its bytes
    task automatic load(input logic [71:0] b, input logic s);
        for (int k = 0; k < 9; k++) begin
            img[k] = b[71-8*k -: 8];
            u_ncl_mem_model.image[addrs[k]] = img[k];
        end
        slow = s;
        u_ncl_mem_model.seen.delete();
        pulses = 0;
        do_reset(1'b0, 1'b1);
        chk(u_ncl_mem_model.seen.size(), 9);
        for (int k = 0; k < 9; k++) chk(u_ncl_mem_model.seen[k], addrs[k]);
        chk(flag_attributes_register, {img[0][7], img[0][0] & img[0][7], img[1][1], img[1][0],
            img[1][6], img[1][5], img[1][4]});
        chk(pulses, img[1][0]);
        chk(hardware_configuration_register, {img[2][3:0], img[7][3:2], img[7][1]});
        chk(phy_indication_register, {img[4], img[3], img[6], img[5]});
        chk(interchip_link_enable_register, {img[8][7:6], img[7][5]});
        chk(usb_config, {img[8][5:3], img[7][4]});
    endtask : load
    // drive ready and link mode, then compare {o, oe_n}
    task automatic pin(input logic rdy, input logic lnk, input logic [1:0] exp);
        @(negedge clk_sys);
        usb_attach_ready = rdy;
        interchip_link_mode = lnk;
        repeat (4) @(negedge clk_sys);
        chk({attach_pin_o, attach_pin_oe_n}, exp);
    endtask : pin
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : give_verdict
    ////////////////////////////////////////////////////////////////////////////
    // watchdog: the whole run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end
    // main sequence
    initial begin
        // push-pull, active high, exact match on, filter load
        load(72'h81_73_0a_5c_3e_a5_96_2e_d8, 1'b0);
        pin(1'b0, 1'b1, 2'b00);
        pin(1'b1, 1'b1, 2'b10);
        pin(1'b1, 1'b0, 2'b00);
        // no memory, protected indication registers survive
        do_reset(1'b1, 1'b0);
        chk(phy_indication_register, {img[4], img[3], img[6], img[5]});
        chk(flag_attributes_register, 0);
        do_reset(1'b0, 1'b0);
        chk(phy_indication_register, 0);
        // slow memory, master wake off, open drain active low
        load(72'h01_21_05_12_34_56_78_1c_38, 1'b1);
        pin(1'b1, 1'b1, 2'b00);
        pin(1'b0, 1'b1, 2'b01);
        // attach disabled: type and polarity ignored
        load(72'h80_52_0f_9f_e1_00_ff_d2_40, 1'b0);
        pin(1'b1, 1'b1, 2'b01);
        pin(1'b0, 1'b1, 2'b01);
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
